// ---- inc/cps_defines.svh ----
// cps_defines.svh: offsets, bit positions, reset values and encodings
// assumes inclusion by bare name from the package and design files
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH
`define CPS_ADDR_W          8
`define CPS_OFS_PROFILE_A   8'h12
`define CPS_OFS_LEGACY      8'h13
`define CPS_OFS_PIN_STATE   8'h14
`define CPS_BIT_NO_HANDSHAKE_FLAG       7
`define CPS_BIT_UVLO        4
`define CPS_BIT_USER        3
`define CPS_BIT_DCP         2
`define CPS_BIT_CDP         1
`define CPS_BIT_PT          0
`define CPS_BIT_PEN         6
`define CPS_BIT_M2          5
`define CPS_BIT_M1          4
`define CPS_BIT_EMEN        3
`define CPS_BIT_POL         2
`define CPS_LEGACY_N        7
`define CPS_RESET_VAL       8'h00
`define CPS_PS_SLEEP        2'h0
`define CPS_PS_DETECT       2'h1
`define CPS_PS_ACTIVE       2'h2
`define CPS_PS_ERROR        2'h3
`define CPS_STRAP_SETTLE    2'h2
`endif

// ---- inc/cps_pkg.sv ----
// cps_pkg: types of the charger profile status bank
// assumes cps_defines.svh on the include path
`include "cps_defines.svh"
package cps_pkg;
   typedef enum logic [3:0] {
      CPS_PROF_NONE,
      CPS_PROF_USER,
      CPS_PROF_DCP,
      CPS_PROF_CDP,
      CPS_PROF_LEGACY
   } cps_prof_t;
   typedef enum logic [1:0] {
      CPS_ST_SLEEP,
      CPS_ST_DETECT,
      CPS_ST_ACTIVE,
      CPS_ST_ERROR
   } cps_pstate_t;
endpackage : cps_pkg

// ---- rtl/cps_sync.sv ----
// cps_sync: two-flop synchroniser, one per bit
// assumes inputs are asynchronous levels from pins
module cps_sync #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         clock_i,
   input  wire logic         reset_n_i,
   // data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_r;
   logic [W-1:0] sync_nxt;
   if (W < 1) begin : g_bad_width
      $error("cps_sync width must be positive");
   end
   always_comb begin
      meta_nxt = async_i;
      sync_nxt = meta_r;
   end
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end
   assign sync_o = sync_r;
endmodule : cps_sync

// ---- rtl/cps_status_bank.sv ----
// cps_status_bank: read-only profile, legacy and pin status registers
// assumes the management port delivers one-cycle read/write strobes with an
// address on the core clock, and sequencer events arrive as one-cycle pulses
// Function
// - Profile bits never drive alert/attach; accept bits clear on off, mode, removal.
// - No-handshake set only in dedicated cycle after failed profile; cleared on new.
// - No-handshake never set together with any other profile bit.
// - Undervolt flag follows supply below lockout threshold, self-clearing.
// - User profile handshake in dedicated cycle sets user bit; switch and limit follow custom.
// - Dedicated profile accept sets bit; switch per dedicated bit, constant limit.
// - Downstream handshake sets bit; switch closed, trip limit.
// - Passthrough mode sets bit; switch closed, trip limit.
// - Passthrough bit not re-set after reattach until mode one toggles.
// - Legacy one to seven map to bits 0-6; switch dedicated, custom limit.
// - Legacy bits also steer switch and limit; clear on off, mode, removal.
// - Effective power enable, pin or override, mirrored continuously.
// - Mode two, mode one, emulation enable mirrored into bits 5,4,3.
// - Polarity strap decoded at power-up; 0 active low, 1 active high.
// - Power state field 00 sleep, 01 detect, 10 active, 11 error.
// - Any bus access wakes, so reads never return sleep.
`include "cps_defines.svh"
module cps_status_bank
   import cps_pkg::*;
#(
   parameter int LEGACY_N = `CPS_LEGACY_N
) (
   // clock and reset
   input  wire logic                   clock_i,
   input  wire logic                   reset_n_i,
   // management port
   input  wire logic                   bus_rd_i,
   input  wire logic                   bus_wr_i,
   input  wire logic [`CPS_ADDR_W-1:0] bus_addr_i,
   output logic      [7:0]             bus_rdata_o,
   output logic                        bus_rvalid_o,
   output logic                        bus_wake_o,
   // control pins (asynchronous)
   input  wire logic                   power_enable_control_i,
   input  wire logic                   mode_one_control_i,
   input  wire logic                   mode_two_control_i,
   input  wire logic                   emulation_enable_control_i,
   input  wire logic                   polarity_strap_i,
   input  wire logic                   supply_uvlo_i,
   // overrides from switch configuration
   input  wire logic                   pin_ignore_i,
   input  wire logic                   power_enable_override_i,
   input  wire logic                   mode_one_override_i,
   input  wire logic                   mode_two_override_i,
   input  wire logic                   emulation_enable_override_i,
   // sequencer events
   input  wire logic                   dedicated_emulation_cycle_i,
   input  wire logic                   profile_applied_i,
   input  wire logic                   profile_end_no_handshake_flag_i,
   input  wire logic                   profile_accept_i,
   input  wire cps_prof_t              profile_kind_i,
   input  wire logic [2:0]             legacy_index_i,
   input  wire logic                   passthrough_mode_i,
   input  wire logic                   active_mode_change_i,
   input  wire logic                   removal_detect_i,
   input  wire cps_pstate_t            power_state_i,
   input  wire logic                   dedicated_cycle_hs_switch_i,
   input  wire logic                   custom_hs_switch_i,
   // switch and limit steering
   output logic                        hs_switch_close_o,
   output logic                        limit_constant_o,
   output logic                        limit_follow_custom_o
);
   logic [5:0] pins_s;
   logic       pen_eff;
   logic       m1_eff;
   logic       m2_eff;
   logic       emen_eff;
   logic       clr_accept;
   logic       sleep_req;

   logic             no_handshake_flag_r, no_handshake_flag_nxt;
   logic             uvlo_r, uvlo_nxt;
   logic [3:0]       acc_r, acc_nxt;
   logic [LEGACY_N-1:0] leg_r, leg_nxt;
   logic             pt_block_r, pt_block_nxt;
   logic             m1_prev_r, m1_prev_nxt;
   logic             pol_r, pol_nxt;
   logic [1:0]       pol_cnt_r, pol_cnt_nxt;
   logic [4:0]       mirror_r, mirror_nxt;
   logic [1:0]       pstate_r, pstate_nxt;
   logic             awake_r, awake_nxt;
   logic [7:0]       rdata_r, rdata_nxt;
   logic             rvalid_r, rvalid_nxt;
   logic             wake_r, wake_nxt;
   logic             hs_r, hs_nxt;
   logic             lconst_r, lconst_nxt;
   logic             lcust_r, lcust_nxt;

   if (LEGACY_N != 7) begin : g_bad_count
      $error("legacy profile count must be 7");
   end

   cps_sync #(
      .W (6)
   ) u_sync (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .async_i   ({supply_uvlo_i, polarity_strap_i,
                   emulation_enable_control_i, mode_one_control_i,
                   mode_two_control_i, power_enable_control_i}),
      .sync_o    (pins_s)
   );

   // pin ignore hands the control entirely to the override bits
   always_comb begin
      pen_eff  = pin_ignore_i ? power_enable_override_i
                              : (pins_s[0] ~^ pol_r);
      m2_eff   = pin_ignore_i ? mode_two_override_i : pins_s[1];
      m1_eff   = pin_ignore_i ? mode_one_override_i : pins_s[2];
      emen_eff = pin_ignore_i ? emulation_enable_override_i : pins_s[3];
   end

   assign clr_accept = !pen_eff || active_mode_change_i
                       || removal_detect_i;
   assign sleep_req  = bus_rd_i || bus_wr_i;

   // profile status state
   always_comb begin
      no_handshake_flag_nxt    = no_handshake_flag_r;
      acc_nxt      = acc_r;
      leg_nxt      = leg_r;
      pt_block_nxt = pt_block_r;
      m1_prev_nxt  = m1_eff;
      uvlo_nxt     = pins_s[5];
      if (m1_eff != m1_prev_r) begin
         pt_block_nxt = 1'b0;
      end
      if (clr_accept) begin
         acc_nxt = 4'h0;
         leg_nxt = '0;
         if (removal_detect_i && passthrough_mode_i) begin
            pt_block_nxt = 1'b1;
         end
      end
      if (profile_applied_i) begin
         no_handshake_flag_nxt = 1'b0;
      end
      if (profile_end_no_handshake_flag_i && dedicated_emulation_cycle_i) begin
         no_handshake_flag_nxt = 1'b1;
      end
      // set wins over clear for accept events
      if (profile_accept_i) begin
         case (profile_kind_i)
            CPS_PROF_USER: begin
               if (dedicated_emulation_cycle_i)
                  acc_nxt[`CPS_BIT_USER] = 1'b1;
            end
            CPS_PROF_DCP:  acc_nxt[`CPS_BIT_DCP] = 1'b1;
            CPS_PROF_CDP:  acc_nxt[`CPS_BIT_CDP] = 1'b1;
            CPS_PROF_LEGACY: begin
               if (legacy_index_i < 3'(LEGACY_N))
                  leg_nxt[legacy_index_i] = 1'b1;
            end
            default: ;
         endcase
      end
      if (passthrough_mode_i && !pt_block_nxt && pen_eff) begin
         acc_nxt[`CPS_BIT_PT] = 1'b1;
      end
      if ((|acc_nxt) || (|leg_nxt)) begin
         no_handshake_flag_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         no_handshake_flag_r    <= 1'b0;
         uvlo_r     <= 1'b0;
         acc_r      <= 4'h0;
         leg_r      <= '0;
         pt_block_r <= 1'b0;
         m1_prev_r  <= 1'b0;
      end else begin
         no_handshake_flag_r    <= no_handshake_flag_nxt;
         uvlo_r     <= uvlo_nxt;
         acc_r      <= acc_nxt;
         leg_r      <= leg_nxt;
         pt_block_r <= pt_block_nxt;
         m1_prev_r  <= m1_prev_nxt;
      end
   end

   // strap taken after the synchroniser refills; its reset zero is no strap
   always_comb begin
      pol_nxt     = pol_r;
      pol_cnt_nxt = pol_cnt_r;
      if (pol_cnt_r != 2'h3) begin
         pol_cnt_nxt = pol_cnt_r + 2'h1;
         if (pol_cnt_r == `CPS_STRAP_SETTLE) pol_nxt = pins_s[4];
      end
      mirror_nxt = {pen_eff, m2_eff, m1_eff, emen_eff, pol_r};
      awake_nxt  = sleep_req || (awake_r
                   && power_state_i != CPS_ST_SLEEP);
      case (power_state_i)
         CPS_ST_SLEEP:  pstate_nxt = `CPS_PS_SLEEP;
         CPS_ST_DETECT: pstate_nxt = `CPS_PS_DETECT;
         CPS_ST_ACTIVE: pstate_nxt = `CPS_PS_ACTIVE;
         CPS_ST_ERROR:  pstate_nxt = `CPS_PS_ERROR;
         default:       pstate_nxt = `CPS_PS_SLEEP;
      endcase
      if (pstate_nxt == `CPS_PS_SLEEP && (sleep_req || awake_r)) begin
         pstate_nxt = `CPS_PS_DETECT;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         pol_r      <= 1'b0;
         pol_cnt_r  <= 2'h0;
         mirror_r   <= 5'h00;
         awake_r    <= 1'b0;
         pstate_r   <= `CPS_PS_SLEEP;
      end else begin
         pol_r      <= pol_nxt;
         pol_cnt_r  <= pol_cnt_nxt;
         mirror_r   <= mirror_nxt;
         awake_r    <= awake_nxt;
         pstate_r   <= pstate_nxt;
      end
   end

   // read port; writes decode to nothing, reads clear no status bit
   always_comb begin
      rdata_nxt  = rdata_r;
      rvalid_nxt = bus_rd_i;
      wake_nxt   = sleep_req;
      if (bus_rd_i) begin
         case (bus_addr_i)
            `CPS_OFS_PROFILE_A:
               rdata_nxt = {no_handshake_flag_r, 2'h0, uvlo_r, acc_r};
            `CPS_OFS_LEGACY:
               rdata_nxt = {1'b0, leg_r};
            `CPS_OFS_PIN_STATE: begin
               // the wake is not yet in pstate_r, so sleep is returned as detect
               rdata_nxt = {1'b0, mirror_r, (pstate_r == `CPS_PS_SLEEP)
                            ? `CPS_PS_DETECT : pstate_r};
            end
            default: rdata_nxt = `CPS_RESET_VAL;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         rdata_r  <= `CPS_RESET_VAL;
         rvalid_r <= 1'b0;
         wake_r   <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         wake_r   <= wake_nxt;
      end
   end

   // switch and limit steering from the accepted profile
   always_comb begin
      hs_nxt     = 1'b0;
      lconst_nxt = 1'b0;
      lcust_nxt  = 1'b0;
      if (acc_r[`CPS_BIT_USER]) begin
         hs_nxt    = custom_hs_switch_i;
         lcust_nxt = 1'b1;
      end else if (acc_r[`CPS_BIT_DCP]) begin
         hs_nxt     = dedicated_cycle_hs_switch_i;
         lconst_nxt = 1'b1;
      end else if (acc_r[`CPS_BIT_CDP] || acc_r[`CPS_BIT_PT]) begin
         hs_nxt = 1'b1;
      end else if (|leg_r) begin
         hs_nxt    = dedicated_cycle_hs_switch_i;
         lcust_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         hs_r     <= 1'b0;
         lconst_r <= 1'b0;
         lcust_r  <= 1'b0;
      end else begin
         hs_r     <= hs_nxt;
         lconst_r <= lconst_nxt;
         lcust_r  <= lcust_nxt;
      end
   end

   assign bus_rdata_o           = rdata_r;
   assign bus_rvalid_o          = rvalid_r;
   assign bus_wake_o            = wake_r;
   assign hs_switch_close_o     = hs_r;
   assign limit_constant_o      = lconst_r;
   assign limit_follow_custom_o = lcust_r;
endmodule : cps_status_bank

// ---- verif/cps_host_model.sv ----
// cps_host_model: host issuing single-byte management reads and writes
// assumes the bank answers with rvalid exactly one cycle after a read
module cps_host_model (
   // clock
   input  wire logic       clock_i,
   // answer from the bank
   input  wire logic [7:0] bus_rdata_i,
   input  wire logic       bus_rvalid_i,
   // request to the bank
   output logic            bus_rd_o,
   output logic            bus_wr_o,
   output logic [7:0]      bus_addr_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      bus_rd_o = 1'b0;
      bus_wr_o = 1'b0;
      bus_addr_o = 8'h5a;
   end
   // a released address shows its inverse so no stale value is reused
   task automatic access(input logic wr, input logic [7:0] a,
                         output logic [7:0] d);
      @(posedge clock_i);
      #1;
      bus_rd_o = !wr;
      bus_wr_o = wr;
      bus_addr_o = a;
      @(posedge clock_i);
      #1;
      bus_rd_o = 1'b0;
      bus_wr_o = 1'b0;
      bus_addr_o = ~a;
      d = bus_rvalid_i ? bus_rdata_i : 8'hxx;
   endtask : access
endmodule : cps_host_model

// ---- verif/cps_status_bank_properties.sv ----
// cps_status_bank_properties: timing and value checks at the bank ports
// assumes a bind onto cps_status_bank from the bench top file
`include "cps_defines.svh"
module cps_status_bank_properties
   import cps_pkg::*;
#(
   parameter int LEGACY_N = 7
) (
   // clock and reset
   input wire logic                   clock_i,
   input wire logic                   reset_n_i,
   // management port
   input wire logic                   bus_rd_i,
   input wire logic                   bus_wr_i,
   input wire logic [`CPS_ADDR_W-1:0] bus_addr_i,
   input wire logic [7:0]             bus_rdata_o,
   input wire logic                   bus_rvalid_o,
   input wire logic                   bus_wake_o,
   // sequencer and steering
   input wire logic                   profile_accept_i,
   input wire cps_prof_t              profile_kind_i,
   input wire logic                   dedicated_cycle_hs_switch_i,
   input wire logic                   dedicated_emulation_cycle_i,
   input wire logic                   custom_hs_switch_i,
   input wire logic                   hs_switch_close_o,
   input wire logic                   limit_constant_o,
   input wire logic                   limit_follow_custom_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);
   AST_RD_ANSWER: assert property (bus_rd_i |=> bus_rvalid_o)
      else $error("read not answered next cycle");
   AST_RDATA_HOLD: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
      else $error("read data moved without a read");
   AST_WAKE: assert property ((bus_rd_i || bus_wr_i) |=> bus_wake_o)
      else $error("access gave no wake request");
   AST_NEVER_SLEEP: assert property (bus_rvalid_o &&
      $past(bus_addr_i) == `CPS_OFS_PIN_STATE |-> bus_rdata_o[1:0] != 2'h0)
      else $error("power state read as sleep");
   AST_NOHS_ALONE: assert property (bus_rvalid_o && bus_rdata_o[7] &&
      $past(bus_addr_i) == `CPS_OFS_PROFILE_A |-> bus_rdata_o[3:0] == 4'h0)
      else $error("no-handshake flag beside a profile bit");
   AST_LEGACY_SPAN: assert property (bus_rvalid_o &&
      $past(bus_addr_i) == `CPS_OFS_LEGACY |-> bus_rdata_o[7:LEGACY_N] == '0)
      else $error("legacy bits beyond the profile count");
   AST_UNMAPPED: assert property (bus_rvalid_o && !($past(bus_addr_i)
      inside {8'h12, 8'h13, 8'h14}) |-> bus_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   // steering is registered behind the status bits, hence two edges after the accept
   AST_CDP_STEER: assert property (profile_accept_i &&
      profile_kind_i == CPS_PROF_CDP |-> ##[1:3] (hs_switch_close_o &&
      !limit_constant_o && !limit_follow_custom_o))
      else $error("downstream accept steering wrong");
   AST_DCP_STEER: assert property (profile_accept_i &&
      profile_kind_i == CPS_PROF_DCP |-> ##[1:3] (limit_constant_o &&
      hs_switch_close_o == dedicated_cycle_hs_switch_i))
      else $error("dedicated accept steering wrong");
   AST_LEGACY_STEER: assert property (profile_accept_i &&
      profile_kind_i == CPS_PROF_LEGACY |-> ##[1:3] (limit_follow_custom_o
      && hs_switch_close_o == dedicated_cycle_hs_switch_i))
      else $error("legacy accept steering wrong");
   AST_USER_STEER: assert property (profile_accept_i &&
      profile_kind_i == CPS_PROF_USER && dedicated_emulation_cycle_i |->
      ##[1:3] (limit_follow_custom_o && !limit_constant_o &&
      hs_switch_close_o == custom_hs_switch_i))
      else $error("user accept steering wrong");
endmodule : cps_status_bank_properties

// ---- verif/test_cps_status_bank.sv ----
// test_cps_status_bank: self-checking bench for the profile status bank
// assumes cps_host_model drives the management port
`include "cps_defines.svh"
module test_cps_status_bank
   import cps_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_i, reset_n_i, rd_s, wr, rvalid;
   logic [7:0]  addr, rdata, d, e12, e13, seed;
   logic        en_pin, mode1, mode2, emu_pin, pol, uvlo, ign, thru;
   logic        en_ov, mode1_ov, mode2_ov, emu_ov, dcycle, hsw_ded;
   logic [4:0]  ev;
   logic [2:0]  lidx;
   cps_prof_t   kind;
   cps_pstate_t pstate;
   int          errors, checks, cyc, i, j;
   cps_status_bank #(.LEGACY_N(`CPS_LEGACY_N)) cps_status_bank_i (
      .clock_i, .reset_n_i, .bus_rd_i(rd_s), .bus_wr_i(wr),
      .bus_addr_i(addr), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid),
      .bus_wake_o(), .power_enable_control_i(en_pin),
      .mode_one_control_i(mode1), .mode_two_control_i(mode2),
      .emulation_enable_control_i(emu_pin), .polarity_strap_i(pol),
      .supply_uvlo_i(uvlo), .pin_ignore_i(ign),
      .power_enable_override_i(en_ov), .mode_one_override_i(mode1_ov),
      .mode_two_override_i(mode2_ov), .emulation_enable_override_i(emu_ov),
      .dedicated_emulation_cycle_i(dcycle), .profile_applied_i(ev[0]),
      .profile_end_no_handshake_flag_i(ev[1]), .profile_accept_i(ev[2]),
      .profile_kind_i(kind), .legacy_index_i(lidx),
      .passthrough_mode_i(thru), .active_mode_change_i(ev[3]),
      .removal_detect_i(ev[4]), .power_state_i(pstate),
      .dedicated_cycle_hs_switch_i(hsw_ded), .custom_hs_switch_i(emu_ov),
      .hs_switch_close_o(), .limit_constant_o(), .limit_follow_custom_o());
   cps_host_model cps_host_model_i (.clock_i, .bus_rdata_i(rdata),
      .bus_rvalid_i(rvalid), .bus_rd_o(rd_s), .bus_wr_o(wr),
      .bus_addr_o(addr));
   always #4 clock_i = !clock_i;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function automatic logic [7:0] exp14();
      return {1'b0, ign ? en_ov : (en_pin ~^ pol), ign ? mode2_ov : mode2,
              ign ? mode1_ov : mode1, ign ? emu_ov : emu_pin, pol,
              pstate == CPS_ST_SLEEP ? 2'h1 : pstate};
   endfunction : exp14
   task automatic close_out;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic wt(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : wt
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      cps_host_model_i.access(1'b0, a, d);
      checks++;
      if (d !== x) begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, d, x);
      end
   endtask : rd
   // model follows each event pulse; an accept wins over a clear
   task automatic fire(input logic [4:0] m);
      wt(1);
      ev = m;
      wt(1);
      ev = 5'h00;
      if (m[4] || m[3]) {e12[3:0], e13} = 12'h000;
      if (m[0] || m[2]) e12[7] = 1'b0;
      if (m[1] && dcycle) e12[7] = 1'b1;
      if (m[2]) begin
         case (kind)
            CPS_PROF_USER: e12[3] = e12[3] | dcycle;
            CPS_PROF_DCP: e12[2] = 1'b1;
            CPS_PROF_CDP: e12[1] = 1'b1;
            default: e13[lidx] = 1'b1;
         endcase
      end
   endtask : fire
   task automatic clr(input int s);
      if (s < 2)
         fire(s == 0 ? 5'h08 : 5'h10);
      else begin
         {ign, en_ov} = 2'b10;
         wt(4);
         ign = 1'b0;
         {e12[3:0], e13} = 12'h000;
         wt(4);
      end
   endtask : clr
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      {clock_i, reset_n_i, en_pin, mode1, mode2, emu_pin, pol, uvlo} = '0;
      {ign, thru, en_ov, mode1_ov, mode2_ov, emu_ov, dcycle, hsw_ded} = '0;
      {ev, lidx, errors, checks, cyc} = '0;
      kind = CPS_PROF_NONE;
      pstate = CPS_ST_SLEEP;
      seed = 8'h1a;
      for (j = 0; j < 2; j++) begin
         {pol, en_pin, ign, thru, dcycle, uvlo, reset_n_i} = {j[0], j[0], 5'h0};
         wt(12);
         reset_n_i = 1'b1;
         {e12, e13} = 16'h0000;
         wt(4);
         rd(8'h12, e12);
         rd(8'h13, e13);
         for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            {ign, en_ov, mode1_ov, mode2_ov, emu_ov, hsw_ded} = seed[5:0];
            seed = lfsr(seed);
            {en_pin, mode1, mode2, emu_pin} = seed[3:0];
            pstate = cps_pstate_t'(i[1:0]);
            wt(4);
            rd(8'h14, exp14());
         end
         {ign, en_pin, mode1} = {1'b0, pol, 1'b0};
         pstate = CPS_ST_ACTIVE;
         kind = CPS_PROF_USER;
         fire(5'h06);
         rd(8'h12, e12);
         dcycle = 1'b1;
         for (i = 0; i < 3; i++) begin
            fire(5'h02);
            cps_host_model_i.access(1'b1, 8'h12 + 8'(i), d);
            rd(8'h12, e12);
            kind = cps_prof_t'(i + 1);
            fire(5'h04);
            rd(8'h12, e12);
            clr(i);
            rd(8'h12, e12);
         end
         fire(5'h02);
         fire(5'h01);
         rd(8'h12, e12);
         kind = CPS_PROF_LEGACY;
         for (i = 0; i < 7; i++) begin
            lidx = 3'(i);
            fire(5'h04);
            rd(8'h13, e13);
            clr(i % 3);
            rd(8'h13, e13);
         end
         uvlo = 1'b1;
         wt(4);
         rd(8'h12, e12 | 8'h10);
         uvlo = 1'b0;
         wt(4);
         rd(8'h12, e12);
         rd(8'h11, 8'h00);
         rd(seed | 8'h20, 8'h00);
         {dcycle, thru} = 2'b01;
         wt(4);
         rd(8'h12, 8'h01);
         fire(5'h10);
         wt(4);
         rd(8'h12, 8'h00);
         mode1 = 1'b1;
         wt(4);
         mode1 = 1'b0;
         wt(4);
         rd(8'h12, 8'h01);
      end
      close_out();
   end
endmodule : test_cps_status_bank
bind cps_status_bank cps_status_bank_properties #(.LEGACY_N(LEGACY_N))
   props_i (.clock_i, .reset_n_i, .bus_rd_i, .bus_wr_i, .bus_addr_i,
      .bus_rdata_o, .bus_rvalid_o, .bus_wake_o, .profile_accept_i,
      .profile_kind_i, .dedicated_cycle_hs_switch_i, .hs_switch_close_o,
      .limit_constant_o, .limit_follow_custom_o, .dedicated_emulation_cycle_i,
      .custom_hs_switch_i);
